/* File: pkg/ecx_pkg.sv */
package ecx_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_FUNC_MODE = 8'h03;
   localparam logic [7:0] IDX_IF_FORMAT = 8'h04;
   localparam logic [7:0] IDX_MISC = 8'h05;
   localparam logic [7:0] IDX_STATUS = 8'h06;
   localparam logic [7:0] IDX_SAMPLE_BASE = 8'h08;
   localparam int ADDR_W = 12;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int FM_PLAY_SPEED_LSB = 6;
   localparam int FM_REC_SPEED_LSB = 4;
   localparam int FM_OUT_CLK_SEL = 0;
   localparam int IF_FORMAT_LSB = 4;
   localparam int IF_REC_OL_LSB = 2;
   localparam int IF_PLAY_OL_LSB = 0;
   localparam int MC_PLAY_MASTER = 7;
   localparam int MC_REC_MASTER = 6;
   localparam int MC_EXT_CLK_SRC = 5;
   localparam int ST_RX_ACTIVE = 0;
   localparam int ST_CFG_BAD = 1;
   localparam int ST_RATE_ERR = 2;
   localparam int ST_QUAD_ERR = 3;
   localparam int ST_FRAME_LEFT = 4;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_FUNC_MODE = 8'h00;
   localparam logic [7:0] RST_IF_FORMAT = 8'h00;
   localparam logic [7:0] RST_MISC = 8'h00;

   // ------------------------------------------------------------
   // Codes and counts
   // ------------------------------------------------------------
   localparam logic [1:0] SPEED_SINGLE = 2'b00;
   localparam logic [1:0] SPEED_DOUBLE = 2'b01;
   localparam logic [1:0] SPEED_QUAD = 2'b10;
   localparam logic [1:0] OL_OFF = 2'b00;
   localparam logic [1:0] OL_MODE1 = 2'b01;
   localparam logic [1:0] OL_MODE2 = 2'b10;
   localparam int SAMPLE_BITS = 24;
   localparam logic [7:0] HALF_BITS_64FS = 8'h20;
   localparam logic [7:0] HALF_BITS_128FS = 8'h40;
endpackage

/* File: hw/ecx_sample_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module ecx_sample_mem #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 2,
   parameter int AW = 1
) (
   input wire logic mclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata_r
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge mclk) begin
      rdata_r <= mem[raddr];
   end
endmodule // ecx_sample_mem
`default_nettype wire

/* File: hw/ecx_ext_conv_rx.sv */
// Contract
// R01 - Converter inputs: left-justified 24-bit, 64/128Fs
// R02 - Fixed format, ignores port format bits
// R03 - Inputs used only in single-line mode
// R04 - Data sampled on selected bit clock rise
// R05 - Single speed accepts 64 or 128Fs
// R06 - Double speed accepts only 64Fs
// R07 - Quad speed not usable for converters
// R08 - Clock-source bit: 1 playback, 0 record
// R09 - Config 1: 24-bit 48kHz all channels
// R10 - Config 1: both speed fields equal
// R11 - Output select 0: playback clocks drive output
// R12 - Output select 1: record clocks drive output
// R13 - Config 1: both ports master
// R14 - Config 1: source bit 0, select 0
// R15 - Config 2: 20-bit at 96kHz
// R16 - Config 2: each port speed independent
// R17 - Config 2: masters, source 1, select 1
// R18 - Config 2: playback mode 00 or 01
// R19 - Format field only outside single-line mode
// R20 - Mode fields select mode, reject invalid
// R21 - Mode 1: 20-bit, 128Fs, single/double
// R22 - Mode 2: 24-bit, 256Fs, single, master
// R23 - Codes 00 off, 01 mode1, 10 mode2
// R24 - Samples MSB first from frame edge
`timescale 1ns/1ps
`default_nettype none
module ecx_ext_conv_rx (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ecx_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic playback_bit_clock,
   input wire logic playback_frame_clock,
   input wire logic record_bit_clock,
   input wire logic record_frame_clock,
   input wire logic ext_conv_data_in_a,
   input wire logic ext_conv_data_in_b,
   output logic record_serial_out,
   output logic conv_rx_active
);
   localparam int SW = ecx_pkg::SAMPLE_BITS;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic rate_ok(input logic [1:0] speed, input logic [7:0] bits);
      rate_ok = (bits == ecx_pkg::HALF_BITS_64FS) ||
                (speed == ecx_pkg::SPEED_SINGLE && bits == ecx_pkg::HALF_BITS_128FS); // R05 R06
   endfunction

   function automatic logic [2:0] pick(input logic sel, input logic [2:0] a, input logic [2:0] b);
      pick = sel ? a : b;
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] func_mode_r, if_format_r, misc_r, idx;
   logic rate_err_r, quad_err_r, wait_r, wr_now;
   logic out_clk_sel, ext_clk_src, play_master, rec_master;
   logic [1:0] play_speed, rec_speed, play_ol, rec_ol;
   logic [2:0] format_sel;

   assign idx = paddr[9:2];
   assign wr_now = psel && penable && pready && pwrite;
   assign play_speed = func_mode_r[ecx_pkg::FM_PLAY_SPEED_LSB +: 2];
   assign rec_speed = func_mode_r[ecx_pkg::FM_REC_SPEED_LSB +: 2];
   assign out_clk_sel = func_mode_r[ecx_pkg::FM_OUT_CLK_SEL];
   assign play_ol = if_format_r[ecx_pkg::IF_PLAY_OL_LSB +: 2];
   assign rec_ol = if_format_r[ecx_pkg::IF_REC_OL_LSB +: 2];
   assign format_sel = if_format_r[ecx_pkg::IF_FORMAT_LSB +: 3];
   assign play_master = misc_r[ecx_pkg::MC_PLAY_MASTER];
   assign rec_master = misc_r[ecx_pkg::MC_REC_MASTER];
   assign ext_clk_src = misc_r[ecx_pkg::MC_EXT_CLK_SRC];

   always_ff @(posedge mclk) begin
      if (rst) begin
         func_mode_r <= ecx_pkg::RST_FUNC_MODE;
         if_format_r <= ecx_pkg::RST_IF_FORMAT;
         misc_r <= ecx_pkg::RST_MISC;
      end else if (wr_now) begin
         case (idx)
            ecx_pkg::IDX_FUNC_MODE: func_mode_r <= pwdata[7:0];
            ecx_pkg::IDX_IF_FORMAT: if_format_r <= pwdata[7:0];
            ecx_pkg::IDX_MISC: misc_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Mode check
   // ------------------------------------------------------------
   // Config 1 when converters use record clocks, config 2 otherwise
   logic cfg_bad, sel_speed, single_line, rx_en;
   logic [1:0] conv_speed;

   always_comb begin
      cfg_bad = 1'b0;
      if (play_ol == 2'b11 || rec_ol == 2'b11) begin
         cfg_bad = 1'b1; // R20 R23
      end
      if ((play_ol == ecx_pkg::OL_MODE1 && play_speed == ecx_pkg::SPEED_QUAD) ||
          (rec_ol == ecx_pkg::OL_MODE1 && rec_speed == ecx_pkg::SPEED_QUAD)) begin
         cfg_bad = 1'b1; // R21
      end
      if ((play_ol == ecx_pkg::OL_MODE2 &&
           (play_speed != ecx_pkg::SPEED_SINGLE || !play_master)) ||
          (rec_ol == ecx_pkg::OL_MODE2 &&
           (rec_speed != ecx_pkg::SPEED_SINGLE || !rec_master))) begin
         cfg_bad = 1'b1; // R22
      end
      if (!ext_clk_src) begin
         // R09 R10 R13 R14
         if (play_speed != rec_speed || !play_master || !rec_master || out_clk_sel) begin
            cfg_bad = 1'b1;
         end
      end else begin
         // R15 R16 R17 R18
         if (!play_master || !rec_master || !out_clk_sel || play_ol == ecx_pkg::OL_MODE2) begin
            cfg_bad = 1'b1;
         end
      end
   end

   assign sel_speed = ext_clk_src;
   assign conv_speed = sel_speed ? play_speed : rec_speed; // R08
   assign single_line = (play_ol != ecx_pkg::OL_OFF) || (rec_ol != ecx_pkg::OL_OFF); // R19
   assign rx_en = single_line && !cfg_bad && conv_speed != ecx_pkg::SPEED_QUAD; // R03 R07

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [5:0] pin_s1_r, pin_s2_r, pin_prev_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_s1_r <= 6'h00;
         pin_s2_r <= 6'h00;
         pin_prev_r <= 6'h00;
      end else begin
         pin_s1_r <= {ext_conv_data_in_b, ext_conv_data_in_a, record_frame_clock,
                      record_bit_clock, playback_frame_clock, playback_bit_clock};
         pin_s2_r <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
      end
   end

   // Bit 0 bclk, bit 1 fclk, bit 2 previous bclk
   logic [2:0] conv_clk, out_clk;
   logic conv_rise, out_fall;

   assign conv_clk = pick(ext_clk_src, {pin_prev_r[0], pin_s2_r[1:0]},
                          {pin_prev_r[2], pin_s2_r[3:2]}); // R08
   assign out_clk = pick(out_clk_sel, {pin_prev_r[2], pin_s2_r[3:2]},
                         {pin_prev_r[0], pin_s2_r[1:0]}); // R11 R12
   assign conv_rise = conv_clk[0] && !conv_clk[2]; // R04
   assign out_fall = !out_clk[0] && out_clk[2];

   // ------------------------------------------------------------
   // Converter capture
   // ------------------------------------------------------------
   // Format field is never consulted here: converters are always left-justified
   logic conv_fclk_r, mem_we_r, mem_waddr_r, conv_edge;
   logic [7:0] bit_cnt_r;
   logic [SW-1:0] shift_a_r, shift_b_r, last_a_r, last_b_r;
   logic [47:0] mem_rdata;

   assign conv_edge = conv_clk[1] != conv_fclk_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         conv_fclk_r <= 1'b0;
         bit_cnt_r <= 8'h00;
         shift_a_r <= '0;
         shift_b_r <= '0;
      end else if (conv_rise) begin
         conv_fclk_r <= conv_clk[1];
         if (conv_edge) begin
            bit_cnt_r <= 8'h01; // R24
            shift_a_r <= {{(SW-1){1'b0}}, pin_s2_r[4]};
            shift_b_r <= {{(SW-1){1'b0}}, pin_s2_r[5]};
         end else begin
            if (bit_cnt_r != 8'hff) begin
               bit_cnt_r <= bit_cnt_r + 8'h01;
            end
            if (bit_cnt_r < 8'(SW)) begin
               shift_a_r <= {shift_a_r[SW-2:0], pin_s2_r[4]}; // R01 R02 R24
               shift_b_r <= {shift_b_r[SW-2:0], pin_s2_r[5]};
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mem_we_r <= 1'b0;
         mem_waddr_r <= 1'b0;
         last_a_r <= '0;
         last_b_r <= '0;
      end else begin
         mem_we_r <= 1'b0;
         if (rx_en && conv_rise && !conv_edge && bit_cnt_r == 8'(SW)) begin
            mem_we_r <= 1'b1;
            mem_waddr_r <= !conv_fclk_r;
            last_a_r <= shift_a_r;
            last_b_r <= shift_b_r;
         end
      end
   end

   // Rate check on each frame half; a first half after enable may flag spuriously
   always_ff @(posedge mclk) begin
      if (rst) begin
         rate_err_r <= 1'b0;
      end else if (rx_en && conv_rise && conv_edge && bit_cnt_r != 8'h00 &&
                   !rate_ok(conv_speed, bit_cnt_r)) begin
         rate_err_r <= 1'b1; // R01 R05 R06
      end else if (wr_now && idx == ecx_pkg::IDX_STATUS && pwdata[ecx_pkg::ST_RATE_ERR]) begin
         rate_err_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         quad_err_r <= 1'b0;
      end else if (single_line && conv_speed == ecx_pkg::SPEED_QUAD) begin
         quad_err_r <= 1'b1; // R07
      end else if (wr_now && idx == ecx_pkg::IDX_STATUS && pwdata[ecx_pkg::ST_QUAD_ERR]) begin
         quad_err_r <= 1'b0;
      end
   end

   ecx_sample_mem #(.WIDTH(48), .DEPTH(2), .AW(1)) u_mem (
      .mclk(mclk),
      .we(mem_we_r),
      .waddr(mem_waddr_r),
      .wdata({shift_a_r, shift_b_r}),
      .raddr(idx[1]),
      .rdata_r(mem_rdata)
   );

   // ------------------------------------------------------------
   // Merged record stream
   // ------------------------------------------------------------
   // Line a then line b in each half, MSB first, changed on falling bclk
   logic out_fclk_r;
   logic [47:0] out_shift_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         out_fclk_r <= 1'b0;
         out_shift_r <= '0;
         record_serial_out <= 1'b0;
      end else if (!rx_en) begin
         record_serial_out <= 1'b0;
         out_shift_r <= '0;
      end else if (out_fall) begin
         out_fclk_r <= out_clk[1];
         if (out_clk[1] != out_fclk_r) begin
            record_serial_out <= last_a_r[SW-1]; // R03
            out_shift_r <= {last_a_r[SW-2:0], last_b_r, 1'b0};
         end else begin
            record_serial_out <= out_shift_r[47];
            out_shift_r <= {out_shift_r[46:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         conv_rx_active <= 1'b0;
      end else begin
         conv_rx_active <= rx_en;
      end
   end

   // ------------------------------------------------------------
   // APB slave: two wait cycles, one-cycle pready
   // ------------------------------------------------------------
   logic mapped;
   logic [31:0] rd_mux;

   assign mapped = idx == ecx_pkg::IDX_FUNC_MODE || idx == ecx_pkg::IDX_IF_FORMAT ||
                   idx == ecx_pkg::IDX_MISC || idx == ecx_pkg::IDX_STATUS ||
                   (idx[7:2] == ecx_pkg::IDX_SAMPLE_BASE[7:2]);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (idx)
         ecx_pkg::IDX_FUNC_MODE: rd_mux[7:0] = func_mode_r;
         ecx_pkg::IDX_IF_FORMAT: rd_mux[7:0] = if_format_r;
         ecx_pkg::IDX_MISC: rd_mux[7:0] = misc_r;
         ecx_pkg::IDX_STATUS: begin
            rd_mux[ecx_pkg::ST_RX_ACTIVE] = rx_en;
            rd_mux[ecx_pkg::ST_CFG_BAD] = cfg_bad; // R20
            rd_mux[ecx_pkg::ST_RATE_ERR] = rate_err_r;
            rd_mux[ecx_pkg::ST_QUAD_ERR] = quad_err_r;
            rd_mux[ecx_pkg::ST_FRAME_LEFT] = conv_fclk_r;
            rd_mux[7:5] = format_sel;
         end
         default: begin
            if (mapped) begin
               rd_mux[SW-1:0] = idx[0] ? mem_rdata[SW-1:0] : mem_rdata[47:SW];
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wait_r <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         wait_r <= psel && penable && !wait_r && !pready;
         pready <= psel && penable && wait_r;
         pslverr <= psel && penable && wait_r && !mapped;
         if (psel && penable && wait_r && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end
endmodule // ecx_ext_conv_rx
`default_nettype wire

/* File: verif/ecx_ext_conv_rx_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ecx_ext_conv_rx_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ecx_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic playback_bit_clock,
   input wire logic playback_frame_clock,
   input wire logic record_bit_clock,
   input wire logic record_frame_clock,
   input wire logic ext_conv_data_in_a,
   input wire logic ext_conv_data_in_b,
   input wire logic record_serial_out,
   input wire logic conv_rx_active
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic [3:0] since_wr_r;
   logic mapped;
   assign mapped = paddr inside {12'h00C, 12'h010, 12'h014, 12'h018,
                                 12'h020, 12'h024, 12'h028, 12'h02C};
   // Receiver enable only follows register writes
   always_ff @(posedge mclk) begin
      if (rst || (pready && pwrite)) since_wr_r <= 4'h0;
      else if (since_wr_r != 4'hF) since_wr_r <= since_wr_r + 4'h1;
   end
   a_ready_third: assert property ($rose(psel && penable) |-> !pready [*2] ##1 pready)
      else $error("pready not in third access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not match address map");
   a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("refused read data not zero");
   a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:24] == 8'h00)
      else $error("upper read bits not zero");
   a_prdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
      else $error("read data changed without a read");
   a_active_cause: assert property ($changed(conv_rx_active) |-> since_wr_r < 4'h6)
      else $error("receiver enable changed without a write");
   a_reset_quiet: assert property ($fell(rst) |-> !pready && !conv_rx_active && !record_serial_out)
      else $error("outputs not quiet after reset");
endmodule // ecx_ext_conv_rx_chk
`default_nettype wire

/* File: verif/ecx_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ecx_conv_model (
   output logic bclk,
   output logic fclk,
   output logic data_a,
   output logic data_b
);
   // Bit clock stands still between frames
   initial begin
      bclk = 1'b0;
      fclk = 1'b0;
      data_a = 1'b0;
      data_b = 1'b0;
   end
   task automatic send_frame(input logic [23:0] la, lb, ra, rb, input int half);
      logic [23:0] wa;
      logic [23:0] wb;
      for (int h = 0; h < 2; h++) begin
         wa = (h == 0) ? la : ra;
         wb = (h == 0) ? lb : rb;
         for (int i = 0; i < half; i++) begin
            fclk = (h == 0);
            data_a = (i < 24) ? wa[23-i] : ~wa[0];
            data_b = (i < 24) ? wb[23-i] : ~wb[0];
            #24 bclk = 1'b1;
            #24 bclk = 0;
         end
      end
      // Released lines must not look like held data
      data_a = ~data_a;
      data_b = ~data_b;
   endtask
endmodule // ecx_conv_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, use_play, err;
   logic [ecx_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic m_bclk, m_fclk, m_da, m_db, rso, active, both;
   logic [63:0] cap;
   wire pb_b, pb_f, rc_b, rc_f;
   int n_errors = 0;
   int checks = 0;
   assign pb_b = (use_play | both) & m_bclk;
   assign pb_f = (use_play | both) & m_fclk;
   assign rc_b = (!use_play | both) & m_bclk;
   assign rc_f = (!use_play | both) & m_fclk;
   ecx_ext_conv_rx i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .playback_bit_clock(pb_b), .playback_frame_clock(pb_f),
      .record_bit_clock(rc_b), .record_frame_clock(rc_f), .ext_conv_data_in_a(m_da),
      .ext_conv_data_in_b(m_db), .record_serial_out(rso), .conv_rx_active(active));
   ecx_conv_model i_model (.bclk(m_bclk), .fclk(m_fclk), .data_a(m_da), .data_b(m_db));
   // Merged stream taken as a host would, on the playback bit clock rise, right halves only
   always @(posedge pb_b) begin
      if (pb_f === 1'b0) begin
         cap <= {cap[62:0], rso};
      end
   end
   // ------------------------------------------------------------
   // Bus and compare helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      chk("pready", 32'h0000_0001, {31'h0, pready});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wait_act(input logic exp);
      for (int i = 0; i < 10 && active !== exp; i++) @(posedge mclk);
      chk("rx active", {31'h0, exp}, {31'h0, active});
   endtask
   task automatic frame(input logic [23:0] la, lb, ra, rb, input int half);
      i_model.send_frame(la, lb, ra, rb, half);
      @(posedge mclk);
   endtask
   task automatic samples(input logic [23:0] la, lb, ra, rb);
      apb(1'b0, 12'h020, 32'h0);
      chk("left a", {8'h00, la}, rd);
      apb(1'b0, 12'h024, 32'h0);
      chk("left b", {8'h00, lb}, rd);
      apb(1'b0, 12'h028, 32'h0);
      chk("right a", {8'h00, ra}, rd);
      apb(1'b0, 12'h02C, 32'h0);
      chk("right b", {8'h00, rb}, rd);
   endtask
   task automatic rate_err(input logic [31:0] exp);
      apb(1'b0, 12'h018, 32'h0);
      chk("rate error", exp, rd & 32'h0000_0004);
      apb(1'b1, 12'h018, 32'h0000_000C);
   endtask
   task automatic setup(input logic [31:0] misc, func, ifmt, input logic play);
      use_play <= play;
      apb(1'b1, 12'h014, misc);
      apb(1'b1, 12'h00C, func);
      apb(1'b1, 12'h010, ifmt);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      apb(1'b0, 12'h00C, 32'h0);
      chk("func reset", 32'h0, rd);
      apb(1'b0, 12'h010, 32'h0);
      chk("ifmt reset", 32'h0, rd);
      apb(1'b0, 12'h014, 32'h0);
      chk("misc reset", 32'h0, rd);
      apb(1'b1, 12'h030, 32'h0000_00FF);
      chk("bad write err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h030, 32'h0);
      chk("bad read err", 32'h1, {31'h0, err});
      chk("bad read data", 32'h0, rd);
      $display("test regs done");
   endtask
   task automatic t_cfg1;
      setup(32'h0000_00C0, 32'h0000_0000, 32'h0000_0054, 1'b0);
      wait_act(1'b1);
      frame(24'h12_3456, 24'h65_4321, 24'hAB_CDEF, 24'h0F_0F0F, 32);
      rate_err(32'h0000_0000);
      // Both ports carry the same frame in this configuration
      both <= 1'b1;
      frame(24'h80_0001, 24'h7F_FFFE, 24'hC0_0003, 24'h3F_FFFC, 64);
      both <= 1'b0;
      rate_err(32'h0);
      chk("stream a", 32'h0080_0001, {8'h00, cap[63:40]});
      chk("stream b", 32'h007F_FFFE, {8'h00, cap[39:16]});
      chk("stream tail", 32'h0000_0000, {16'h0000, cap[15:0]});
      samples(24'h80_0001, 24'h7F_FFFE, 24'hC0_0003, 24'h3F_FFFC);
      $display("test config one done");
   endtask
   task automatic t_double;
      setup(32'h0000_00C0, 32'h0000_0050, 32'h0000_0004, 1'b0);
      frame(24'h11_1111, 24'h22_2222, 24'h33_3333, 24'h44_4444, 32);
      apb(1'b1, 12'h018, 32'h0000_000C);
      frame(24'h55_5555, 24'h66_6666, 24'h77_7777, 24'h88_8888, 64);
      rate_err(32'h0000_0004);
      $display("test double speed done");
   endtask
   task automatic t_cfg2;
      setup(32'h0000_00E0, 32'h0000_0011, 32'h0000_0001, 1'b1);
      wait_act(1'b1);
      frame(24'hA5_A5A5, 24'h5A_5A5A, 24'hF0_0F00, 24'h00_F00F, 32);
      samples(24'hA5_A5A5, 24'h5A_5A5A, 24'hF0_0F00, 24'h00_F00F);
      $display("test config two done");
   endtask
   task automatic t_refuse;
      apb(1'b1, 12'h00C, 32'h0000_00A1);
      wait_act(1'b0);
      apb(1'b0, 12'h018, 32'h0);
      chk("status quad", 32'h0000_000A, rd);
      frame(24'hDE_AD00, 24'hBE_EF00, 24'hCA_FE00, 24'hFA_CE00, 32);
      samples(24'hA5_A5A5, 24'h5A_5A5A, 24'hF0_0F00, 24'h00_F00F);
      apb(1'b1, 12'h00C, 32'h0000_0001);
      apb(1'b1, 12'h018, 32'h0000_0008);
      wait_act(1'b1);
      apb(1'b1, 12'h010, 32'h0000_0002);
      wait_act(1'b0);
      apb(1'b1, 12'h010, 32'h0000_000D);
      apb(1'b0, 12'h018, 32'h0);
      chk("status code", 32'h0000_0002, rd);
      apb(1'b1, 12'h010, 32'h0000_0070);
      wait_act(1'b0);
      apb(1'b0, 12'h018, 32'h0);
      chk("status off", 32'h0000_00E0, rd);
      $display("test refusal done");
   endtask
   task automatic end_of_test;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      #200_000;
      n_errors++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      use_play = 1'b0;
      both = 1'b0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_regs();
      t_cfg1();
      t_double();
      t_cfg2();
      t_refuse();
      end_of_test();
   end
endmodule // tb
bind ecx_ext_conv_rx ecx_ext_conv_rx_chk i_chk (.mclk(mclk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .playback_bit_clock(playback_bit_clock),
   .playback_frame_clock(playback_frame_clock), .record_bit_clock(record_bit_clock),
   .record_frame_clock(record_frame_clock), .ext_conv_data_in_a(ext_conv_data_in_a),
   .ext_conv_data_in_b(ext_conv_data_in_b), .record_serial_out(record_serial_out),
   .conv_rx_active(conv_rx_active));
`default_nettype wire
